// [nv_cfg_bank.sv]
`timescale 1ns/1ps
module nv_cfg_bank (
    // Clock and reset
    input  wire  logic                      clk_i,
    input  wire  logic                      rst_i,
    // Register port from the serial interface
    input  wire  nv_cfg_pkg::reg_req_t      req_i,
    output logic [7:0]                      rdata_o,
    // Power manager and configuration page image
    input  wire  logic                      above_second_low_voltage_threshold_i,
    input  wire  nv_cfg_pkg::nv_image_t     nv_image_i,
    output logic                            cfg_loaded_o,
    // Thermometer result
    input  wire  logic                      temp_meas_valid_i,
    input  wire  logic [7:0]                temp_meas_i,
    output logic [7:0]                      temperature_o,
    // Control outputs
    output logic [3:0]                      charge_res_en_o,
    output logic [1:0]                      clock_output_pin_sel_o,
    output logic                            therm_en_o,
    output logic                            temp_scan_period_sel_o,
    output nv_cfg_pkg::crystal_comp_t       crystal_comp_o
);
    import nv_cfg_pkg::*;

    // ==========================================================
    // Supply threshold synchroniser (asynchronous analog level)
    logic        vthr_meta_reg;
    logic        vthr_sync_reg;
    logic        vthr_prev_reg;
    logic        loaded_reg;
    logic        loaded_next;
    logic        load_go;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vthr_meta_reg <= 1'b0;
            vthr_sync_reg <= 1'b0;
            vthr_prev_reg <= 1'b0;
        end else begin
            vthr_meta_reg <= above_second_low_voltage_threshold_i;
            vthr_sync_reg <= vthr_meta_reg;
            vthr_prev_reg <= vthr_sync_reg;
        end
    end

    // Load once per reset; a later dip does not overwrite host settings
    assign load_go = vthr_sync_reg && !vthr_prev_reg && !loaded_reg;

    // ==========================================================
    // Register storage
    nv_control_t     ctrl_reg,     ctrl_next;
    crystal_offset_t xofs_reg,     xofs_next;
    logic [7:0]      xcoef_reg,    xcoef_next;
    logic [5:0]      xturn_reg,    xturn_next;
    logic [7:0]      temp_reg,     temp_next;
    logic [7:0]      rdata_reg,    rdata_next;
    logic [7:0]      scratch_reg  [SCRATCH_COUNT];
    logic [7:0]      scratch_next [SCRATCH_COUNT];
    logic            scratch_hit;
    logic [SCRATCH_IDX_W-1:0] scratch_idx;

    assign scratch_hit = (req_i.addr >= OFS_SCRATCH_FIRST) && (req_i.addr <= OFS_SCRATCH_LAST);
    assign scratch_idx = req_i.addr[SCRATCH_IDX_W-1:0];

    always_comb begin
        ctrl_next  = ctrl_reg;
        xofs_next  = xofs_reg;
        xcoef_next = xcoef_reg;
        xturn_next = xturn_reg;
        temp_next  = temp_reg;
        loaded_next = loaded_reg || load_go;
        if (load_go) begin
            ctrl_next  = nv_image_i.control;
            xofs_next  = nv_image_i.offset;
            xcoef_next = nv_image_i.coef;
            xturn_next = nv_image_i.turnover[5:0];
        end else if (req_i.wr) begin
            // Host writes to crystal data are accepted; keeping them is the host's duty
            unique case (req_i.addr)
                OFS_NV_CONTROL:   ctrl_next  = nv_control_t'(req_i.wdata);
                OFS_CRYSTAL_OFS:  xofs_next  = crystal_offset_t'(req_i.wdata);
                OFS_CRYSTAL_COEF: xcoef_next = req_i.wdata;
                OFS_CRYSTAL_TURN: xturn_next = req_i.wdata[5:0];
                default:          ;
            endcase
        end
        // Thermometer owns the result while enabled; host only when disabled
        if (ctrl_reg.therm_en) begin
            if (temp_meas_valid_i) begin
                temp_next = temp_meas_i;
            end
        end else if (req_i.wr && req_i.addr == OFS_TEMPERATURE) begin
            temp_next = req_i.wdata;
        end
    end

    // ==========================================================
    // Scratch bytes, one per entry
    generate
        for (genvar i = 0; i < SCRATCH_COUNT; i++) begin : g_scratch
            always_comb begin
                scratch_next[i] = scratch_reg[i];
                if (req_i.wr && scratch_hit && scratch_idx == SCRATCH_IDX_W'(i)) begin
                    scratch_next[i] = req_i.wdata;
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    scratch_reg[i] <= BYTE_RESET;
                end else begin
                    scratch_reg[i] <= scratch_next[i];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read path, registered one cycle after the read strobe
    always_comb begin
        rdata_next = rdata_reg;
        if (req_i.rd) begin
            if (scratch_hit) begin
                rdata_next = scratch_reg[scratch_idx];
            end else begin
                unique case (req_i.addr)
                    OFS_TEMPERATURE:  rdata_next = temp_reg;
                    OFS_NV_CONTROL:   rdata_next = ctrl_reg;
                    OFS_CRYSTAL_OFS:  rdata_next = xofs_reg;
                    OFS_CRYSTAL_COEF: rdata_next = xcoef_reg;
                    OFS_CRYSTAL_TURN: rdata_next = {2'b00, xturn_reg} & TURNOVER_MASK;
                    default:          rdata_next = UNMAPPED_READ;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg   <= nv_control_t'(BYTE_RESET);
            xofs_reg   <= crystal_offset_t'(BYTE_RESET);
            xcoef_reg  <= BYTE_RESET;
            xturn_reg  <= BYTE_RESET[5:0];
            temp_reg   <= BYTE_RESET;
            rdata_reg  <= BYTE_RESET;
            loaded_reg <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            xofs_reg   <= xofs_next;
            xcoef_reg  <= xcoef_next;
            xturn_reg  <= xturn_next;
            temp_reg   <= temp_next;
            rdata_reg  <= rdata_next;
            loaded_reg <= loaded_next;
        end
    end

    // ==========================================================
    // Outputs
    assign rdata_o                = rdata_reg;
    assign cfg_loaded_o           = loaded_reg;
    assign temperature_o          = temp_reg;
    assign charge_res_en_o        = {ctrl_reg.charge_res_large_en, ctrl_reg.charge_res_mid_en,
                                     ctrl_reg.charge_res_small_en, ctrl_reg.charge_res_min_en};
    assign clock_output_pin_sel_o = {ctrl_reg.clock_output_pin_sel_hi, ctrl_reg.clock_output_pin_sel_lo};
    assign therm_en_o             = ctrl_reg.therm_en;
    assign temp_scan_period_sel_o = ctrl_reg.temp_scan_period_sel;
    assign crystal_comp_o         = {xofs_reg, xcoef_reg, xturn_reg};

    // ==========================================================
    // Assertions
    a_load_copies_image: assert property (@(posedge clk_i) disable iff (rst_i)
        load_go && !req_i.wr |=> ctrl_reg == $past(nv_image_i.control) && loaded_reg)
        else $error("configuration not loaded from image");
    a_load_only_once: assert property (@(posedge clk_i) disable iff (rst_i)
        loaded_reg |=> loaded_reg ##0 !load_go)
        else $error("configuration load repeated");
    a_turn_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == OFS_CRYSTAL_TURN |=> rdata_o[7:6] == 2'b00)
        else $error("turnover upper bits not zero");
    a_scratch_roundtrip: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.wr && scratch_hit ##1 req_i.rd && !req_i.wr
            && req_i.addr == $past(req_i.addr) |=> rdata_o == $past(req_i.wdata, 2))
        else $error("scratch byte lost");
    a_temp_host_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
        therm_en_o && !temp_meas_valid_i |=> $stable(temperature_o))
        else $error("temperature changed without measurement");
    a_temp_host_write: assert property (@(posedge clk_i) disable iff (rst_i)
        !therm_en_o && req_i.wr && req_i.addr == OFS_TEMPERATURE
            |=> temperature_o == $past(req_i.wdata))
        else $error("host temperature write dropped");
    a_ctrl_write_fields: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.wr && req_i.addr == OFS_NV_CONTROL && !load_go
            |=> charge_res_en_o == $past(req_i.wdata[7:4])
            && clock_output_pin_sel_o == $past(req_i.wdata[3:2]))
        else $error("control fields mismatch");
    a_comp_offset_map: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.wr && req_i.addr == OFS_CRYSTAL_OFS && !load_go
            |=> crystal_comp_o.crystal_offset_value == $past(req_i.wdata))
        else $error("offset not passed to compensation");
    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == 8'h34 |=> rdata_o == UNMAPPED_READ)
        else $error("unmapped address not zero");

    c_load:        cover property (@(posedge clk_i) disable iff (rst_i) load_go);
    c_scratch_rd:  cover property (@(posedge clk_i) disable iff (rst_i) req_i.rd && scratch_hit);
    c_temp_write:  cover property (@(posedge clk_i) disable iff (rst_i)
        !therm_en_o && req_i.wr && req_i.addr == OFS_TEMPERATURE);
    c_therm_on:    cover property (@(posedge clk_i) disable iff (rst_i)
        therm_en_o && temp_meas_valid_i);
endmodule

// [nv_cfg_pkg.sv]
// Summary of operation
// - Configuration page holds four non-volatile bytes: control, offset, coefficient, turnover.
// - Control bits 7 to 4 each connect one trickle-charge resistor when set.
// - Control bits 3 and 2 form a code selecting the clock output frequency.
// - Control bit 1 enables the thermometer; bit 0 selects 1 s or 16 s scan.
// - Offset bits 6 to 0 hold the compensation magnitude, valid 0 to 121.
// - Coefficient register holds the unsigned quadratic drift coefficient, 0 to 255.
// - Turnover bits 5 to 0 hold turnover temperature 4 to 67 C; bits 7, 6 unused.
// - Offset, coefficient and turnover feed the frequency compensation unit.
// - Eight volatile scratch bytes at 38h to 3Fh, freely readable and writable.
// - Configuration loads from the non-volatile page once supply passes second threshold.
// - With thermometer disabled the host may write the temperature result register.
package nv_cfg_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_TEMPERATURE   = 8'h20;
    localparam logic [7:0] OFS_NV_CONTROL    = 8'h30;
    localparam logic [7:0] OFS_CRYSTAL_OFS   = 8'h31;
    localparam logic [7:0] OFS_CRYSTAL_COEF  = 8'h32;
    localparam logic [7:0] OFS_CRYSTAL_TURN  = 8'h33;
    localparam logic [7:0] OFS_SCRATCH_FIRST = 8'h38;
    localparam logic [7:0] OFS_SCRATCH_LAST  = 8'h3F;

    // ==========================================================
    // Sizes, masks and reset values
    localparam int         SCRATCH_COUNT     = 8;
    localparam int         SCRATCH_IDX_W     = 3;
    localparam int         CFG_BYTES         = 4;
    localparam logic [7:0] TURNOVER_MASK     = 8'h3F;
    localparam logic [7:0] BYTE_RESET        = 8'h00;
    localparam logic [7:0] UNMAPPED_READ     = 8'h00;

    // ==========================================================
    // Field layouts
    typedef struct packed {
        logic charge_res_large_en;
        logic charge_res_mid_en;
        logic charge_res_small_en;
        logic charge_res_min_en;
        logic clock_output_pin_sel_hi;
        logic clock_output_pin_sel_lo;
        logic therm_en;
        logic temp_scan_period_sel;
    } nv_control_t;

    typedef struct packed {
        logic       sign_faster;
        logic [6:0] magnitude;
    } crystal_offset_t;

    typedef struct packed {
        crystal_offset_t crystal_offset_value;
        logic [7:0]      crystal_quadratic_coef_value;
        logic [5:0]      crystal_turnover_value;
    } crystal_comp_t;

    typedef struct packed {
        nv_control_t     control;
        crystal_offset_t offset;
        logic [7:0]      coef;
        logic [7:0]      turnover;
    } nv_image_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// [host_model.sv]
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire  logic                 clk_i,
    // Register port towards the bank
    output nv_cfg_pkg::reg_req_t       req_o,
    input  wire  logic [7:0]           rdata_i
);
    import nv_cfg_pkg::*;

    // ==========================================================
    // Bus cycles, driven on the falling edge
    initial req_o = '0;

    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        // Factory calibration is never touched by this host
        if (addr inside {[OFS_CRYSTAL_OFS:OFS_CRYSTAL_TURN]}) return;
        @(negedge clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge clk_i);
        req_o.wr = 1'b0;
    endtask

    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clk_i);
        req_o.rd = 1'b0;
        data = rdata_i;
    endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
    import nv_cfg_pkg::*;

    logic          clk = 1'b0;
    logic          rst = 1'b1;
    reg_req_t      req;
    logic [7:0]    rdata;
    logic          thr = 1'b0;
    nv_image_t     image = '0;
    logic          loaded;
    logic          tvalid = 1'b0;
    logic [7:0]    tmeas = 8'h00;
    logic [7:0]    temperature;
    logic [3:0]    res_en;
    logic [1:0]    clk_sel;
    logic          therm_en;
    logic          period;
    crystal_comp_t comp;
    int            fails = 0;
    int            checked = 0;

    nv_cfg_bank dut (.clk_i(clk), .rst_i(rst), .req_i(req), .rdata_o(rdata),
        .above_second_low_voltage_threshold_i(thr), .nv_image_i(image),
        .cfg_loaded_o(loaded), .temp_meas_valid_i(tvalid), .temp_meas_i(tmeas),
        .temperature_o(temperature), .charge_res_en_o(res_en),
        .clock_output_pin_sel_o(clk_sel), .therm_en_o(therm_en),
        .temp_scan_period_sel_o(period), .crystal_comp_o(comp));
    host_model host (.clk_i(clk), .req_o(req), .rdata_i(rdata));

    // ==========================================================
    // Clock, compare and verdict
    initial forever #12.5 clk = ~clk;

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_read(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.read_byte(addr, d);
        check_val("read data", {24'h0, exp}, {24'h0, d});
    endtask

    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset();
        check_val("loaded", 32'h0, {31'h0, loaded});
        check_val("comp", 32'h0, {10'h0, comp});
        check_read(OFS_NV_CONTROL, 8'h00);
    endtask

    task automatic test_load();
        image = {8'hA6, 8'hF9, 8'hFF, 8'hC4};
        @(negedge clk);
        thr = 1'b1;
        repeat (10) if (loaded !== 1'b1) @(negedge clk);
        check_val("loaded", 32'h1, {31'h0, loaded});
        check_val("res_en", 32'hA, {28'h0, res_en});
        check_val("clk_sel", 32'h1, {30'h0, clk_sel});
        check_val("therm", 32'h2, {30'h0, therm_en, period});
        check_val("comp", {10'h0, 8'hF9, 8'hFF, 6'h04}, {10'h0, comp});
        check_read(OFS_NV_CONTROL, 8'hA6);
        check_read(OFS_CRYSTAL_OFS, 8'hF9);
        check_read(OFS_CRYSTAL_COEF, 8'hFF);
        check_read(OFS_CRYSTAL_TURN, 8'h04);
        image = '0;
        thr = 1'b0;
        repeat (4) @(negedge clk);
        thr = 1'b1;
        repeat (6) @(negedge clk);
        check_val("res_en", 32'hA, {28'h0, res_en});
    endtask

    task automatic test_control();
        for (int c = 0; c < 4; c++) begin
            host.write_byte(OFS_NV_CONTROL, {4'h5, c[1:0], 1'b0, c[0]});
            check_val("clk_sel", c, {30'h0, clk_sel});
            check_val("res_en", 32'h5, {28'h0, res_en});
            check_val("therm", {31'h0, c[0]}, {30'h0, therm_en, period});
        end
        host.write_byte(OFS_TEMPERATURE, 8'h3C);
        check_val("temperature", 32'h3C, {24'h0, temperature});
        host.write_byte(OFS_NV_CONTROL, 8'h02);
        host.write_byte(OFS_TEMPERATURE, 8'h11);
        check_val("temperature", 32'h3C, {24'h0, temperature});
        tmeas = 8'h5A;
        tvalid = 1'b1;
        @(negedge clk);
        tvalid = 1'b0;
        check_val("temperature", 32'h5A, {24'h0, temperature});
    endtask

    task automatic test_scratch();
        for (int i = 0; i < SCRATCH_COUNT; i++)
            host.write_byte(OFS_SCRATCH_FIRST + 8'(i), 8'hFF - 8'(i * 36));
        for (int i = 0; i < SCRATCH_COUNT; i++)
            check_read(OFS_SCRATCH_FIRST + 8'(i), 8'hFF - 8'(i * 36));
        host.write_byte(8'h40, 8'h77);
        check_read(8'h40, 8'h00);
        check_read(8'h34, 8'h00);
    endtask

    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        test_reset();
        test_load();
        test_control();
        test_scratch();
        print_verdict();
    end

    // Whole run is about 80 cycles; a hang is cut at 4000 cycles, well beyond that
    initial begin
        #(25 * 4000);
        fails++;
        print_verdict();
    end
endmodule
